// ==== inc/var_pkg.sv ====
// ==========================================================
// video adc input route select: shared constants and types
package var_pkg;

  // ========================================================
  // register map
  localparam logic [7:0] VAR_ADDR_NEG = 8'h60;
  localparam logic [7:0] VAR_ADDR_PRI_SEC = 8'hc3;
  localparam logic [7:0] VAR_ADDR_MAN_THIRD = 8'hc4;
  localparam int VAR_MAN_EN_BIT = 7;
  localparam int VAR_LO_LSB = 0;
  localparam int VAR_HI_LSB = 4;
  localparam int VAR_SEL_W = 4;
  localparam int VAR_PIN_W = 8;
  localparam int VAR_FMT_W = 5;
  localparam logic [7:0] VAR_RD_ZERO = 8'h00;
  localparam logic [3:0] VAR_SEL_RST = 4'h0;
  localparam logic VAR_MAN_RST = 1'b0;

  // ========================================================
  // selector codes and pin numbers (0 means no connect)
  localparam logic [3:0] VAR_CODE_NONE = 4'h0;
  localparam logic [3:0] VAR_CODE_1 = 4'h1;
  localparam logic [3:0] VAR_CODE_2 = 4'h2;
  localparam logic [3:0] VAR_CODE_3 = 4'h3;
  localparam logic [3:0] VAR_CODE_4 = 4'h4;
  localparam logic [3:0] VAR_CODE_5 = 4'h5;
  localparam logic [3:0] VAR_CODE_6 = 4'h6;
  localparam logic [3:0] VAR_CODE_8 = 4'h8;
  localparam logic [3:0] VAR_PIN_NONE = 4'h0;
  localparam logic [7:0] VAR_ONEHOT_1 = 8'h01;
  localparam logic [7:0] VAR_NO_PINS = 8'h00;

  // ========================================================
  // input format select ranges and automatic routing pins
  localparam logic [4:0] VAR_FMT_YC_FIRST = 5'h08;
  localparam logic [4:0] VAR_FMT_COMP_FIRST = 5'h0c;
  localparam logic [4:0] VAR_FMT_COMP_LAST = 5'h0f;
  localparam logic [3:0] VAR_AUTO_PIN_PRI = 4'h1;
  localparam logic [3:0] VAR_AUTO_PIN_SEC = 4'h2;
  localparam logic [3:0] VAR_AUTO_PIN_THIRD = 4'h3;

  typedef enum logic [1:0] {
    VAR_FMT_CVBS = 2'b00,
    VAR_FMT_YC = 2'b01,
    VAR_FMT_COMP = 2'b10,
    VAR_FMT_DIFF = 2'b11
  } var_fmt_e;

  typedef enum logic [1:0] {
    VAR_CH_PRI = 2'b00,
    VAR_CH_NEG = 2'b01,
    VAR_CH_SEC = 2'b10,
    VAR_CH_THIRD = 2'b11
  } var_chan_e;

  typedef struct packed {
    logic manualEn;
    logic [3:0] primarySel;
    logic [3:0] secondSel;
    logic [3:0] thirdSel;
    logic [3:0] negativeSel;
  } var_ctrl_s;

  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] negative;
    logic [7:0] second;
    logic [7:0] third;
  } var_route_s;

endpackage : var_pkg

// ==== core/var_route_select.sv ====
// Contract
// - selectors honoured only while manual enable set
// - primary selector in 0xc3 bits 3:0
// - second selector in 0xc3 bits 7:4
// - third selector in 0xc4 bits 3:0
// - negative selector in 0x60, differential variants only
// - negative leg only for differential composite
// - negative powers down only with all others
// - four-input variant selector decode
// - eight-input variant selector decode
// - format select sets decoded format, and sets routing while manual enable clear
`timescale 1ns/1ps
module var_route_select #(
  parameter bit EIGHT_INPUT = 1'b0,
  parameter bit HAS_DIFF = 1'b0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [7:0] regRdata,
  input wire logic [var_pkg::VAR_FMT_W-1:0] inputFormatSelect,
  input wire logic [3:0] chanPowerDownReq,
  output var_pkg::var_route_s route,
  output var_pkg::var_fmt_e fmtKind,
  output logic [3:0] chanPowerDown
);
  import var_pkg::*;

  // ========================================================
  // decode helpers
  function automatic logic [3:0] pinOf(input logic [3:0] code,
                                       input var_chan_e ch,
                                       input bit eight);
    logic [3:0] pin;
    pin = VAR_PIN_NONE;
    unique case (ch)
      VAR_CH_PRI: begin
        if (code != VAR_CODE_NONE &&
            code <= (eight ? VAR_CODE_8 : VAR_CODE_4)) begin
          pin = code;
        end
      end
      VAR_CH_SEC, VAR_CH_NEG: begin
        if (code == VAR_CODE_2 || code == VAR_CODE_4) begin
          pin = code;
        end else if (eight && (code == VAR_CODE_5 ||
                     code == VAR_CODE_6 || code == VAR_CODE_8)) begin
          pin = code;
        end
      end
      VAR_CH_THIRD: begin
        if (code == VAR_CODE_2 || code == VAR_CODE_3) begin
          pin = code;
        end else if (eight && code == VAR_CODE_6) begin
          pin = code;
        end
      end
    endcase
    return pin;
  endfunction : pinOf

  function automatic logic [7:0] oneHot(input logic [3:0] pin);
    logic [7:0] v;
    v = VAR_NO_PINS;
    if (pin != VAR_PIN_NONE) begin
      v = VAR_ONEHOT_1 << (pin - VAR_CODE_1);
    end
    return v;
  endfunction : oneHot

  function automatic var_fmt_e classify(input logic [4:0] fmt);
    var_fmt_e k;
    k = VAR_FMT_CVBS;
    if (fmt >= VAR_FMT_COMP_FIRST && fmt <= VAR_FMT_COMP_LAST) begin
      k = VAR_FMT_COMP;
    end else if (fmt >= VAR_FMT_YC_FIRST && fmt < VAR_FMT_COMP_FIRST) begin
      k = VAR_FMT_YC;
    end
    return k;
  endfunction : classify

  // ========================================================
  // register file
  var_ctrl_s ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    if (regWe) begin
      unique case (regAddr)
        VAR_ADDR_PRI_SEC: begin
          ctrl_next.primarySel = regWdata[VAR_LO_LSB +: VAR_SEL_W];
          ctrl_next.secondSel = regWdata[VAR_HI_LSB +: VAR_SEL_W];
        end
        VAR_ADDR_MAN_THIRD: begin
          ctrl_next.manualEn = regWdata[VAR_MAN_EN_BIT];
          ctrl_next.thirdSel = regWdata[VAR_LO_LSB +: VAR_SEL_W];
        end
        VAR_ADDR_NEG: begin
          // field absent without a differential front end
          if (HAS_DIFF) begin
            ctrl_next.negativeSel = regWdata[VAR_LO_LSB +: VAR_SEL_W];
          end
        end
        default: begin
        end
      endcase
    end
    if (regRe) begin
      unique case (regAddr)
        VAR_ADDR_PRI_SEC: rdata_next = {ctrl_reg.secondSel,
                                        ctrl_reg.primarySel};
        VAR_ADDR_MAN_THIRD: rdata_next = {ctrl_reg.manualEn, 3'h0,
                                          ctrl_reg.thirdSel};
        VAR_ADDR_NEG: rdata_next = {4'h0, ctrl_reg.negativeSel};
        default: rdata_next = VAR_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= '{VAR_MAN_RST, VAR_SEL_RST, VAR_SEL_RST, VAR_SEL_RST,
                    VAR_SEL_RST};
      rdata_reg <= VAR_RD_ZERO;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

  // ========================================================
  // routing and format
  var_route_s route_reg, route_next;
  var_fmt_e fmt_reg, fmt_next;
  logic [3:0] pwr_reg, pwr_next;
  logic [3:0] negPin;

  always_comb begin
    fmt_next = classify(inputFormatSelect);
    route_next = '{VAR_NO_PINS, VAR_NO_PINS, VAR_NO_PINS, VAR_NO_PINS};
    negPin = pinOf(ctrl_reg.negativeSel, VAR_CH_NEG, EIGHT_INPUT);
    if (ctrl_reg.manualEn) begin
      route_next.primary = oneHot(pinOf(ctrl_reg.primarySel,
                                        VAR_CH_PRI, EIGHT_INPUT));
      route_next.second = oneHot(pinOf(ctrl_reg.secondSel,
                                       VAR_CH_SEC, EIGHT_INPUT));
      route_next.third = oneHot(pinOf(ctrl_reg.thirdSel,
                                      VAR_CH_THIRD, EIGHT_INPUT));
      // negative leg only serves a composite input; it then
      // turns the decoded format differential
      if (HAS_DIFF && fmt_next == VAR_FMT_CVBS &&
          negPin != VAR_PIN_NONE) begin
        route_next.negative = oneHot(negPin);
        fmt_next = VAR_FMT_DIFF;
      end
    end else begin
      route_next.primary = oneHot(VAR_AUTO_PIN_PRI);
      if (fmt_next != VAR_FMT_CVBS) begin
        route_next.second = oneHot(VAR_AUTO_PIN_SEC);
      end
      if (fmt_next == VAR_FMT_COMP) begin
        route_next.third = oneHot(VAR_AUTO_PIN_THIRD);
      end
    end
    pwr_next = chanPowerDownReq;
    // a lone negative-leg power down would strand the differential pair
    pwr_next[VAR_CH_NEG] = chanPowerDownReq[VAR_CH_NEG] &
                           chanPowerDownReq[VAR_CH_PRI] &
                           chanPowerDownReq[VAR_CH_SEC] &
                           chanPowerDownReq[VAR_CH_THIRD];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      route_reg <= '{VAR_NO_PINS, VAR_NO_PINS, VAR_NO_PINS, VAR_NO_PINS};
      fmt_reg <= VAR_FMT_CVBS;
      pwr_reg <= 4'h0;
    end else begin
      route_reg <= route_next;
      fmt_reg <= fmt_next;
      pwr_reg <= pwr_next;
    end
  end

  assign route = route_reg;
  assign fmtKind = fmt_reg;
  assign chanPowerDown = pwr_reg;

  // ========================================================
  // checks
  sequence s_wr(logic [7:0] a);
    regWe && regAddr == a;
  endsequence

  property p_wr_pri_sec;
    @(posedge mclk) disable iff (!rstn)
    s_wr(VAR_ADDR_PRI_SEC) |=> ctrl_reg.primarySel == $past(regWdata[3:0])
      && ctrl_reg.secondSel == $past(regWdata[7:4]);
  endproperty
  a_wr_pri_sec: assert property (p_wr_pri_sec)
    else $error("primary/second selector not stored");

  property p_wr_third;
    @(posedge mclk) disable iff (!rstn)
    s_wr(VAR_ADDR_MAN_THIRD) |=> ctrl_reg.thirdSel == $past(regWdata[3:0])
      && ctrl_reg.manualEn == $past(regWdata[7]);
  endproperty
  a_wr_third: assert property (p_wr_third)
    else $error("third selector or manual enable not stored");

  property p_wr_neg;
    @(posedge mclk) disable iff (!rstn)
    s_wr(VAR_ADDR_NEG) |=> ctrl_reg.negativeSel ==
      (HAS_DIFF ? $past(regWdata[3:0]) : 4'h0);
  endproperty
  a_wr_neg: assert property (p_wr_neg)
    else $error("negative selector storage wrong");

  property p_auto_ignores;
    @(posedge mclk) disable iff (!rstn)
    // the release edge still holds reset values, so start one edge later
    rstn && !ctrl_reg.manualEn ##1 (!ctrl_reg.manualEn &&
      $stable(inputFormatSelect)) |=> $stable(route_reg);
  endproperty
  a_auto_ignores: assert property (p_auto_ignores)
    else $error("route moved in automatic mode");

  property p_pri_code1;
    @(posedge mclk) disable iff (!rstn)
    ctrl_reg.manualEn && ctrl_reg.primarySel == 4'h1
      |=> route_reg.primary == 8'h01;
  endproperty
  a_pri_code1: assert property (p_pri_code1)
    else $error("primary code 1 not on pin 1");

  property p_third_code4;
    @(posedge mclk) disable iff (!rstn)
    ctrl_reg.manualEn && ctrl_reg.thirdSel == 4'h4
      |=> route_reg.third == 8'h00;
  endproperty
  a_third_code4: assert property (p_third_code4)
    else $error("third code 4 connected a pin");

  property p_sec_code5;
    @(posedge mclk) disable iff (!rstn)
    ctrl_reg.manualEn && ctrl_reg.secondSel == 4'h5
      |=> route_reg.second == (EIGHT_INPUT ? 8'h10 : 8'h00);
  endproperty
  a_sec_code5: assert property (p_sec_code5)
    else $error("second code 5 decode wrong");

  property p_neg_only_diff;
    @(posedge mclk) disable iff (!rstn)
    route_reg.negative != 8'h00 |-> fmtKind == VAR_FMT_DIFF;
  endproperty
  a_neg_only_diff: assert property (p_neg_only_diff)
    else $error("negative leg used outside differential composite");

  property p_neg_pwr;
    @(posedge mclk) disable iff (!rstn)
    chanPowerDown[1] |-> chanPowerDown[0] && chanPowerDown[2] &&
      chanPowerDown[3];
  endproperty
  a_neg_pwr: assert property (p_neg_pwr)
    else $error("negative channel powered down alone");

  property p_fmt_comp;
    @(posedge mclk) disable iff (!rstn)
    inputFormatSelect == 5'h0c |=> fmtKind == VAR_FMT_COMP;
  endproperty
  a_fmt_comp: assert property (p_fmt_comp)
    else $error("component format not decoded");

endmodule : var_route_select

// ==== tb/var_route_select_bench.sv ====
`timescale 1ns/1ps
module var_route_select_bench;
  import var_pkg::*;
  // ==========================================================
  // two variants share one register port: four-input plain and
  // eight-input differential, so one walk covers both decodes
  logic mclk, rstn, regWe, regRe;
  logic [7:0] regAddr, regWdata, rdA, rdB, d0, d1;
  logic [VAR_FMT_W-1:0] inputFormatSelect;
  logic [3:0] chanPowerDownReq, pdA, pdB, req;
  var_route_s routeA, routeB;
  var_fmt_e fmtA, fmtB;
  int errors, checked;
  logic [23:0] rows [0:15];
  logic [23:0] r;
  logic [3:0] code;

  var_route_select #(.EIGHT_INPUT(1'b0), .HAS_DIFF(1'b0)) i_dut (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWe(regWe), .regRe(regRe), .regRdata(rdA),
    .inputFormatSelect(inputFormatSelect),
    .chanPowerDownReq(chanPowerDownReq), .route(routeA),
    .fmtKind(fmtA), .chanPowerDown(pdA));
  var_route_select #(.EIGHT_INPUT(1'b1), .HAS_DIFF(1'b1)) i_dut_b (
    .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWe(regWe), .regRe(regRe), .regRdata(rdB),
    .inputFormatSelect(inputFormatSelect),
    .chanPowerDownReq(chanPowerDownReq), .route(routeB),
    .fmtKind(fmtB), .chanPowerDown(pdB));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] hot(input logic [3:0] pin);
    return (pin == VAR_PIN_NONE) ? VAR_NO_PINS : VAR_ONEHOT_1 << (pin - 4'h1);
  endfunction : hot

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge mclk);
    regWe <= 1'b0;
  endtask : wr

  // read data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge mclk);
    regRe <= 1'b0;
    #1;
    d0 = rdA;
    d1 = rdB;
  endtask : rd

  // outputs follow the control registers one edge later
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic fmt(input logic [4:0] f);
    @(posedge mclk);
    inputFormatSelect <= f;
    settle();
  endtask : fmt

  task automatic auto(input logic [4:0] f, input logic [31:0] er,
                      input var_fmt_e ek);
    fmt(f);
    chk("auto routeA", er, routeA);
    chk("auto routeB", er, routeB);
    chk("auto kind", {ek, ek}, {fmtA, fmtB});
  endtask : auto

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    regWe = 1'b0;
    regRe = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    inputFormatSelect = 5'h00;
    chanPowerDownReq = 4'h0;
    errors = 0;
    checked = 0;
    // pin numbers {pri4, sec4, third4, pri8, sec8, third8}
    rows = '{1: 24'h100100, 2: 24'h222222, 3: 24'h303303,
             4: 24'h440440, 5: 24'h000550, 6: 24'h000666,
             7: 24'h000700, 8: 24'h000880, default: 24'h000000};
    repeat (16) @(posedge mclk);
    #1;
    chk("reset route", 64'h0, {routeA, routeB});
    chk("reset pd", 8'h00, {pdA, pdB});
    @(posedge mclk);
    rstn <= 1'b1;
    rd(VAR_ADDR_PRI_SEC);
    chk("reset c3", 16'h0, {d0, d1});
    rd(VAR_ADDR_MAN_THIRD);
    chk("reset c4", 16'h0, {d0, d1});
    rd(VAR_ADDR_NEG);
    chk("reset 60", 16'h0, {d0, d1});
    $display("test reset done");

    // selectors loaded but ignored while manual routing is off
    wr(VAR_ADDR_PRI_SEC, 8'h88);
    wr(VAR_ADDR_MAN_THIRD, 8'h08);
    auto(5'h00, 32'h01000000, VAR_FMT_CVBS);
    auto(5'h08, 32'h01000200, VAR_FMT_YC);
    auto(5'h0c, 32'h01000204, VAR_FMT_COMP);
    auto(5'h10, 32'h01000000, VAR_FMT_CVBS);
    $display("test auto done");

    // table: every selector code on primary, second and third, both variants
    fmt(5'h0c);
    for (int i = 0; i < 16; i++) begin
      code = i[3:0];
      r = rows[i];
      wr(VAR_ADDR_PRI_SEC, {code, code});
      wr(VAR_ADDR_MAN_THIRD, {1'b1, 3'b000, code});
      settle();
      chk("routeA", {hot(r[23:20]), 8'h00, hot(r[19:16]), hot(r[15:12])},
          routeA);
      chk("routeB", {hot(r[11:8]), 8'h00, hot(r[7:4]), hot(r[3:0])},
          routeB);
      rd(VAR_ADDR_PRI_SEC);
      chk("c3 back", {code, code, code, code}, {d0, d1});
      rd(VAR_ADDR_MAN_THIRD);
      chk("c4 back", {2{1'b1, 3'b000, code}}, {d0, d1});
    end
    // manual luma/chroma: luma pin 1 on primary, chroma pin 4 on second
    fmt(5'h08);
    wr(VAR_ADDR_PRI_SEC, 8'h41);
    wr(VAR_ADDR_MAN_THIRD, 8'h80);
    settle();
    chk("yc route", {2{32'h01000800}}, {routeA, routeB});
    chk("yc kind", {2{VAR_FMT_YC}}, {fmtA, fmtB});
    $display("test manual table done");

    // negative leg: differential composite only, on the right variant
    fmt(5'h00);
    wr(VAR_ADDR_NEG, 8'hf4);
    wr(VAR_ADDR_PRI_SEC, 8'h02);
    wr(VAR_ADDR_MAN_THIRD, 8'hff);
    settle();
    chk("neg B", {hot(4'h2), hot(4'h4)},
        {routeB.primary, routeB.negative});
    chk("kind diff", {VAR_FMT_CVBS, VAR_FMT_DIFF}, {fmtA, fmtB});
    chk("neg A", 8'h00, routeA.negative);
    rd(VAR_ADDR_NEG);
    chk("60 back", 16'h0004, {d0, d1});
    rd(VAR_ADDR_MAN_THIRD);
    chk("c4 spare bits", 16'h8f8f, {d0, d1});
    wr(VAR_ADDR_NEG, 8'h03);
    settle();
    chk("neg nc", {8'h00, VAR_FMT_CVBS}, {routeB.negative, fmtB});
    wr(VAR_ADDR_NEG, 8'h04);
    wr(VAR_ADDR_MAN_THIRD, 8'h00);
    settle();
    chk("neg auto", 8'h00, routeB.negative);
    wr(8'h3a, 8'hff);
    rd(8'h3a);
    chk("unmapped", 16'h0, {d0, d1});
    $display("test negative done");

    // negative channel may only power down with all others
    for (int i = 0; i < 4; i++) begin
      req = (i == 0) ? 4'h2 : (i == 1) ? 4'hd : (i == 2) ? 4'hf : 4'h7;
      @(posedge mclk);
      chanPowerDownReq <= req;
      settle();
      chk("pd", {2{(req == 4'hf) ? req : (req & 4'hd)}}, {pdA, pdB});
    end
    $display("test power done");

    // reset in mid-run clears registers and outputs at once
    @(posedge mclk);
    rstn <= 1'b0;
    #2;
    chk("mid reset", 64'h0, {routeA, routeB});
    chk("mid reset pd", 8'h00, {pdA, pdB});
    @(posedge mclk);
    rstn <= 1'b1;
    rd(VAR_ADDR_NEG);
    chk("60 after reset", 16'h0, {d0, d1});
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : var_route_select_bench
